//--- shared/rtsab_pkg.sv
// Constants, carriers and states for the subaddress buffer engine
package rtsab_pkg;
   // Word width of the shared RAM and of 1553 words
   localparam int DATA_W = 16;
   // Command word fields
   localparam int CMD_TR_BIT = 10;
   localparam int CMD_SA_LSB = 5;
   localparam int CMD_WC_LSB = 0;
   // Largest word count; a field of zero means this many
   localparam logic [5:0] MAX_WC = 6'h20;
   // Descriptor table layout, four words per subaddress
   localparam logic [15:0] RX_TABLE_OFS = 16'h0000;
   localparam logic [15:0] TX_TABLE_OFS = 16'h0080;
   localparam logic [15:0] CB_CTRL_OFS = 16'h0000;
   localparam logic [15:0] CB_PTR_A_OFS = 16'h0001;
   localparam logic [15:0] CB_PTR_B_OFS = 16'h0002;
   localparam logic [15:0] CB_PTR_BC_OFS = 16'h0003;
   // Control word bit positions
   localparam int CW_IWA_BIT = 14;
   localparam int CW_DPB_BIT = 13;
   localparam int CW_DOUBLE_BUFFER_ENABLE_BIT = 2;
   // Buffer layout: info word, time tag, then data
   localparam logic [15:0] BUF_MIW_OFS = 16'h0000;
   localparam logic [15:0] BUF_DATA_OFS = 16'h0002;
   // Special subaddresses
   localparam logic [4:0] LOOP_SA = 5'h1e;
   localparam logic [4:0] MODE_SA_LO = 5'h00;
   localparam logic [4:0] MODE_SA_HI = 5'h1f;
   // Shared RAM request
   typedef struct packed {
      logic re;
      logic we;
      logic [15:0] addr;
      logic [15:0] wdata;
   } rtsab_mem_req_type;
   // Message sequencer states
   typedef enum logic [3:0] {
      ST_IDLE, ST_CW, ST_PTR, ST_RX_WAIT, ST_RX_COPY, ST_RX_MIW,
      ST_TX_STAT, ST_TX_RD, ST_TX_CAP, ST_TX_PUSH, ST_FIN
   } rtsab_state_type;
endpackage : rtsab_pkg

//--- logic/rtsab_fifo2.sv
// Two-entry valid/ready buffer for outgoing transmit words
`timescale 1ns/1ps
module rtsab_fifo2 #(
   parameter int W = 16
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_in_valid,
   input wire logic [W-1:0] i_in_data,
   output logic o_in_ready,
   output logic o_out_valid,
   output logic [W-1:0] o_out_data,
   input wire logic i_out_ready
);
   typedef struct packed {
      logic [1:0][W-1:0] mem;
      logic wp;
      logic rp;
      logic [1:0] cnt;
   } rtsab_fifo_type;

   rtsab_fifo_type r;
   rtsab_fifo_type next_r;
   logic push;
   logic pop;

   // Handshakes on both sides
   assign push = i_in_valid && (r.cnt != 2'h2);
   assign pop = (r.cnt != 2'h0) && i_out_ready;
   assign o_in_ready = (r.cnt != 2'h2);
   assign o_out_valid = (r.cnt != 2'h0);
   assign o_out_data = r.mem[r.rp];

   // Pointer and count update
   always_comb begin
      next_r = r;
      if (push) begin
         next_r.mem[r.wp] = i_in_data;
         next_r.wp = ~r.wp;
      end
      if (pop) begin
         next_r.rp = ~r.rp;
      end
      if (push && !pop) begin
         next_r.cnt = r.cnt + 2'h1;
      end else if (pop && !push) begin
         next_r.cnt = r.cnt - 2'h1;
      end
   end

   // State register
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
endmodule : rtsab_fifo2

//--- logic/rtsab_core.sv
// Remote-terminal subaddress message engine over shared RAM
//
// Functional notes
// RULE_01: Transmit sends status, then data from pointer
// RULE_02: Word count taken from command, 1 to 32
// RULE_03: Interrupt-when-accessed bit raises interrupt per message
// RULE_04: Host fills transmit buffer before command
// RULE_05: Subaddress 30 shares one buffer both ways
// RULE_06: Ping-pong control block uses pointers A, B, broadcast
// RULE_07: Single-buffer index mode always uses pointer A; the code uses the broadcast pointer for a broadcast receive
// RULE_08: Last control block address and command readable
// RULE_09: Interrupt bit clear: status answered, no interrupt
// RULE_10: Select bit picks A or B, toggles
// RULE_11: Interrupt also needs both enable bits set
// RULE_12: Receive words held until complete, then copied
// RULE_13: Broadcast receive stores through broadcast pointer
`timescale 1ns/1ps
module rtsab_core (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic [15:0] i_desc_base,
   input wire logic i_int_enable,
   input wire logic i_int_out_enable,
   input wire logic i_cmd_valid,
   input wire logic [15:0] i_cmd_word,
   input wire logic i_cmd_broadcast,
   input wire logic i_rx_valid,
   input wire logic [15:0] i_rx_data,
   input wire logic i_rx_error,
   output rtsab_pkg::rtsab_mem_req_type o_mem,
   input wire logic [15:0] i_mem_rdata,
   output logic o_status_req,
   output logic o_tx_valid,
   output logic [15:0] o_tx_data,
   input wire logic i_tx_ready,
   output logic o_irq,
   output logic [15:0] o_cur_cb_addr,
   output logic [15:0] o_cur_cmd,
   output logic o_busy
);
   import rtsab_pkg::*;

   typedef struct packed {
      rtsab_state_type st;
      logic wt;
      logic [15:0] cmd;
      logic bcast;
      logic tr;
      logic [15:0] cb_addr;
      logic [15:0] ctrl;
      logic [15:0] ptr;
      logic [5:0] wc;
      logic [5:0] rx_cnt;
      logic [5:0] idx;
      logic rx_on;
      logic [15:0] hold;
      logic [31:0][15:0] tmp;
      rtsab_mem_req_type mem;
      logic status_req;
      logic irq;
      logic [15:0] cur_cb;
      logic [15:0] cur_cmd;
      logic busy;
   } rtsab_core_type;

   rtsab_core_type r;
   rtsab_core_type next_r;
   logic buf_in_valid;
   logic buf_in_ready;
   logic [4:0] cmd_sa;

   // Zero in the count field stands for the largest count
   function automatic logic [5:0] word_count(input logic [4:0] field);
      return (field == 5'h00) ? MAX_WC : {1'b0, field};
   endfunction : word_count

   assign cmd_sa = i_cmd_word[CMD_SA_LSB +: 5];
   assign buf_in_valid = (r.st == ST_TX_PUSH);

   // Message sequencer
   always_comb begin
      next_r = r;
      next_r.mem.re = 1'b0;
      next_r.mem.we = 1'b0;
      next_r.status_req = 1'b0;
      next_r.irq = 1'b0;
      unique case (r.st)
         ST_IDLE: begin
            if (i_cmd_valid && cmd_sa != MODE_SA_LO && cmd_sa != MODE_SA_HI
                && !(i_cmd_word[CMD_TR_BIT] && i_cmd_broadcast)) begin
               next_r.cmd = i_cmd_word;
               next_r.bcast = i_cmd_broadcast;
               next_r.tr = i_cmd_word[CMD_TR_BIT];
               // RULE_02 count from command
               next_r.wc = word_count(i_cmd_word[CMD_WC_LSB +: 5]);
               // RULE_05 loopback shares receive block
               if (i_cmd_word[CMD_TR_BIT] && cmd_sa != LOOP_SA) begin
                  next_r.cb_addr = i_desc_base + TX_TABLE_OFS + {9'h000, cmd_sa, 2'b00};
               end else begin
                  next_r.cb_addr = i_desc_base + RX_TABLE_OFS + {9'h000, cmd_sa, 2'b00};
               end
               next_r.mem.re = 1'b1;
               next_r.mem.addr = next_r.cb_addr + CB_CTRL_OFS;
               next_r.wt = 1'b0;
               next_r.rx_on = !i_cmd_word[CMD_TR_BIT];
               next_r.rx_cnt = 6'h00;
               next_r.busy = 1'b1;
               next_r.st = ST_CW;
            end
         end
         ST_CW: begin
            if (!r.wt) begin
               next_r.wt = 1'b1;
            end else begin
               next_r.ctrl = i_mem_rdata;
               next_r.mem.re = 1'b1;
               next_r.wt = 1'b0;
               // RULE_13 broadcast pointer
               if (r.bcast && !r.tr) begin
                  next_r.mem.addr = r.cb_addr + CB_PTR_BC_OFS;
               // RULE_06 RULE_10 ping-pong pointer choice
               end else if (i_mem_rdata[CW_DOUBLE_BUFFER_ENABLE_BIT] && i_mem_rdata[CW_DPB_BIT]) begin
                  next_r.mem.addr = r.cb_addr + CB_PTR_B_OFS;
               // RULE_07 single buffer uses pointer A
               end else begin
                  next_r.mem.addr = r.cb_addr + CB_PTR_A_OFS;
               end
               next_r.st = ST_PTR;
            end
         end
         ST_PTR: begin
            if (!r.wt) begin
               next_r.wt = 1'b1;
            end else begin
               next_r.ptr = i_mem_rdata;
               next_r.st = r.tr ? ST_TX_STAT : ST_RX_WAIT;
            end
         end
         ST_RX_WAIT: begin
            // RULE_12 status only after all words
            if (r.rx_cnt == r.wc) begin
               next_r.rx_on = 1'b0;
               next_r.status_req = !r.bcast;
               next_r.idx = 6'h00;
               next_r.st = ST_RX_COPY;
            end
         end
         ST_RX_COPY: begin
            // RULE_12 copy held words to buffer
            next_r.mem.we = 1'b1;
            next_r.mem.addr = r.ptr + BUF_DATA_OFS + {10'h000, r.idx};
            next_r.mem.wdata = r.tmp[r.idx[4:0]];
            next_r.idx = r.idx + 6'h01;
            if (r.idx + 6'h01 == r.wc) begin
               next_r.st = ST_RX_MIW;
            end
         end
         ST_RX_MIW: begin
            // Message info word holds the count
            next_r.mem.we = 1'b1;
            next_r.mem.addr = r.ptr + BUF_MIW_OFS;
            next_r.mem.wdata = {10'h000, r.wc};
            next_r.st = ST_FIN;
         end
         ST_TX_STAT: begin
            // RULE_01 status word first
            next_r.status_req = 1'b1;
            next_r.idx = 6'h00;
            next_r.st = ST_TX_RD;
         end
         ST_TX_RD: begin
            // RULE_01 fetch data from pointer
            next_r.mem.re = 1'b1;
            next_r.mem.addr = r.ptr + BUF_DATA_OFS + {10'h000, r.idx};
            next_r.wt = 1'b0;
            next_r.st = ST_TX_CAP;
         end
         ST_TX_CAP: begin
            if (!r.wt) begin
               next_r.wt = 1'b1;
            end else begin
               next_r.hold = i_mem_rdata;
               next_r.st = ST_TX_PUSH;
            end
         end
         ST_TX_PUSH: begin
            // RULE_02 stop at commanded count
            if (buf_in_ready) begin
               next_r.idx = r.idx + 6'h01;
               next_r.st = (r.idx + 6'h01 == r.wc) ? ST_FIN : ST_TX_RD;
            end
         end
         ST_FIN: begin
            // RULE_10 toggle select after success
            if (r.ctrl[CW_DOUBLE_BUFFER_ENABLE_BIT] && !(r.bcast && !r.tr)) begin
               next_r.mem.we = 1'b1;
               next_r.mem.addr = r.cb_addr + CB_CTRL_OFS;
               next_r.mem.wdata = r.ctrl ^ (16'h0001 << CW_DPB_BIT);
            end
            // RULE_08 last block and command
            next_r.cur_cb = r.cb_addr;
            next_r.cur_cmd = r.cmd;
            // RULE_03 RULE_09 RULE_11 gated interrupt
            next_r.irq = r.ctrl[CW_IWA_BIT] && i_int_enable && i_int_out_enable;
            next_r.busy = 1'b0;
            next_r.st = ST_IDLE;
         end
      endcase
      // RULE_12 gather receive words in holding store
      if (r.rx_on && i_rx_valid) begin
         if (i_rx_error || r.rx_cnt == r.wc) begin
            next_r.rx_on = 1'b0;
            next_r.busy = 1'b0;
            next_r.st = ST_IDLE;
         end else begin
            next_r.tmp[r.rx_cnt[4:0]] = i_rx_data;
            next_r.rx_cnt = r.rx_cnt + 6'h01;
         end
      end
   end

   // State register
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // Outgoing words pass a two-entry buffer
   rtsab_fifo2 #(
      .W(DATA_W)
   ) u_tx_buf (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_in_valid(buf_in_valid),
      .i_in_data(r.hold),
      .o_in_ready(buf_in_ready),
      .o_out_valid(o_tx_valid),
      .o_out_data(o_tx_data),
      .i_out_ready(i_tx_ready)
   );

   assign o_mem = r.mem;
   assign o_status_req = r.status_req;
   assign o_irq = r.irq;
   assign o_cur_cb_addr = r.cur_cb;
   assign o_cur_cmd = r.cur_cmd;
   assign o_busy = r.busy;
endmodule : rtsab_core

//--- bench/rtsab_ram_model.sv
// Shared RAM model on the far side of the engine
`timescale 1ns/1ps
module rtsab_ram_model (
   input wire logic i_clk,
   input wire rtsab_pkg::rtsab_mem_req_type i_mem,
   output logic [15:0] o_rdata
);
   import rtsab_pkg::*;
   logic [15:0] mem [0:65535];
   always @(posedge i_clk) begin
      if (i_mem.we) begin
         mem[i_mem.addr] <= i_mem.wdata;
      end
      // Unread cycles show a changing pattern
      if (i_mem.re) begin
         o_rdata <= mem[i_mem.addr];
      end else begin
         o_rdata <= ~o_rdata;
      end
   end
endmodule : rtsab_ram_model

//--- bench/rtsab_monitor.sv
// Port checker for the subaddress engine
`timescale 1ns/1ps
module rtsab_monitor (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic [15:0] i_desc_base,
   input wire logic i_int_enable,
   input wire logic i_int_out_enable,
   input wire logic i_cmd_valid,
   input wire logic [15:0] i_cmd_word,
   input wire logic i_cmd_broadcast,
   input wire logic i_rx_valid,
   input wire logic i_rx_error,
   input wire rtsab_pkg::rtsab_mem_req_type o_mem,
   input wire logic o_status_req,
   input wire logic o_tx_valid,
   input wire logic [15:0] o_tx_data,
   input wire logic i_tx_ready,
   input wire logic o_irq,
   input wire logic [15:0] o_cur_cmd,
   input wire logic o_busy
);
   import rtsab_pkg::*;
   logic [4:0] sa;
   logic tr;
   logic take;
   logic [15:0] cb_exp;
   // Accepted command and its control block
   assign sa = i_cmd_word[9:5];
   assign tr = i_cmd_word[CMD_TR_BIT];
   assign take = i_cmd_valid && !o_busy && sa != MODE_SA_LO && sa != MODE_SA_HI
      && !(i_cmd_broadcast && tr);
   assign cb_exp = i_desc_base + ((tr && sa != LOOP_SA) ? TX_TABLE_OFS : RX_TABLE_OFS)
      + {9'h000, sa, 2'b00};
   default clocking mcb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   chk_cb_fetch: assert property (take |=> o_mem.re && o_busy && o_mem.addr == $past(cb_exp))
      else $error("control block fetch wrong");
   chk_irq_enables: assert property (o_irq |-> i_int_enable && i_int_out_enable)
      else $error("irq without enables");
   chk_irq_at_end: assert property (o_irq |-> $fell(o_busy))
      else $error("irq not at message end");
   chk_status_pulse: assert property (o_status_req |-> o_busy ##1 !o_status_req)
      else $error("status request malformed");
   chk_mem_excl: assert property (!(o_mem.re && o_mem.we))
      else $error("read and write together");
   chk_cur_update: assert property ($changed(o_cur_cmd) |-> $fell(o_busy))
      else $error("current command moved mid message");
   chk_tx_hold: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
      else $error("stalled word lost");
   chk_err_quiet: assert property (i_rx_valid && i_rx_error |=> (!o_status_req && !o_irq)[*8])
      else $error("errored message answered");
   chk_busy_start: assert property ($rose(o_busy) |-> $past(take))
      else $error("busy without command");
   cov_irq: cover property (o_irq);
   cov_status: cover property (o_status_req);
   cov_stall: cover property (o_tx_valid && !i_tx_ready ##1 o_tx_valid && !i_tx_ready);
endmodule : rtsab_monitor
bind rtsab_core rtsab_monitor rtsab_monitor_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
   .i_desc_base(i_desc_base), .i_int_enable(i_int_enable), .i_int_out_enable(i_int_out_enable),
   .i_cmd_valid(i_cmd_valid), .i_cmd_word(i_cmd_word), .i_cmd_broadcast(i_cmd_broadcast),
   .i_rx_valid(i_rx_valid), .i_rx_error(i_rx_error), .o_mem(o_mem), .o_status_req(o_status_req),
   .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .i_tx_ready(i_tx_ready), .o_irq(o_irq),
   .o_cur_cmd(o_cur_cmd), .o_busy(o_busy));

//--- bench/tb_top.sv
// Self-checking bench for the subaddress engine
`timescale 1ns/1ps
module tb_top;
   import rtsab_pkg::*;
   logic i_clk, i_sys_rst, i_int_enable, i_int_out_enable, i_cmd_valid, i_cmd_broadcast;
   logic i_rx_valid, i_rx_error, i_tx_ready, o_status_req, o_tx_valid, o_irq, o_busy;
   logic [15:0] i_desc_base, i_cmd_word, i_rx_data, i_mem_rdata, o_tx_data, o_cur_cb_addr, o_cur_cmd;
   logic [15:0] mm [0:65535];
   logic [15:0] txq[$], rxq[$], q[$];
   rtsab_mem_req_type o_mem;
   int err_count = 0;
   int checks = 0;
   int seed = 32'h3833;
   int st_n, irq_n, i, j;
   rtsab_core rtsab_core_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_desc_base(i_desc_base),
      .i_int_enable(i_int_enable), .i_int_out_enable(i_int_out_enable), .i_cmd_valid(i_cmd_valid),
      .i_cmd_word(i_cmd_word), .i_cmd_broadcast(i_cmd_broadcast), .i_rx_valid(i_rx_valid),
      .i_rx_data(i_rx_data), .i_rx_error(i_rx_error), .o_mem(o_mem), .i_mem_rdata(i_mem_rdata),
      .o_status_req(o_status_req), .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data),
      .i_tx_ready(i_tx_ready), .o_irq(o_irq), .o_cur_cb_addr(o_cur_cb_addr),
      .o_cur_cmd(o_cur_cmd), .o_busy(o_busy));
   rtsab_ram_model rtsab_ram_model_inst (.i_clk(i_clk), .i_mem(o_mem), .o_rdata(i_mem_rdata));
   // Clock
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   function automatic logic [15:0] rnd();
      return 16'($random(seed));
   endfunction : rnd
   function automatic logic [15:0] cmd(input logic tr, input logic [4:0] sa, input logic [4:0] wc);
      return {5'h01, tr, sa, wc};
   endfunction : cmd
   function automatic logic [15:0] peek(input int a);
      return rtsab_ram_model_inst.mem[a];
   endfunction : peek
   task automatic poke(input int a, input logic [15:0] d);
      rtsab_ram_model_inst.mem[a] = d;
      mm[a] = d;
   endtask : poke
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic tally_and_finish();
      if (err_count == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   // Observer of pulses and accepted words
   always @(posedge i_clk) begin
      if (o_status_req === 1'b1) st_n++;
      if (o_irq === 1'b1) irq_n++;
      if (o_tx_valid === 1'b1 && i_tx_ready === 1'b1) txq.push_back(o_tx_data);
   end
   // Receiver stalls at random
   always @(negedge i_clk) i_tx_ready <= ^rnd();
   // One message: command, receive words, wait for the end
   task automatic msg(input logic [15:0] cw, input logic bc, input int err_at);
      int n;
      int k;
      n = (cw[4:0] == 5'h00) ? 32 : int'(cw[4:0]);
      st_n = 0;
      irq_n = 0;
      txq.delete();
      rxq.delete();
      i_cmd_word = cw;
      i_cmd_broadcast = bc;
      i_cmd_valid = 1'b1;
      @(negedge i_clk);
      i_cmd_valid = 1'b0;
      for (k = 0; k < n && !cw[CMD_TR_BIT]; k++) begin
         rxq.push_back(rnd());
         i_rx_data = rxq[k];
         i_rx_error = (k == err_at);
         i_rx_valid = 1'b1;
         @(negedge i_clk);
         i_rx_valid = 1'b0;
         @(negedge i_clk);
      end
      k = 0;
      while ((o_busy === 1'b1 || o_tx_valid === 1'b1) && k < 3000) begin
         @(negedge i_clk);
         k++;
      end
      if (k == 3000) begin
         err_count++;
         tally_and_finish();
      end else repeat (2) @(negedge i_clk);
   endtask : msg
   // Main sequence
   initial begin
      {i_sys_rst, i_int_enable, i_int_out_enable} = 3'h7;
      {i_cmd_valid, i_cmd_broadcast, i_rx_valid, i_rx_error} = 4'h0;
      {i_desc_base, i_cmd_word, i_rx_data} = {16'h0400, 16'h0000, 16'h0000};
      repeat (10) @(negedge i_clk);
      i_sys_rst = 1'b0;
      poke(16'h0404, 16'h4004);
      poke(16'h0405, 16'h0800);
      poke(16'h0406, 16'h0822);
      poke(16'h0407, 16'h0844);
      poke(16'h0484, 16'h4000);
      poke(16'h0485, 16'h0866);
      poke(16'h0486, 16'h0000);
      poke(16'h0487, 16'h08aa);
      // Loopback block and a block without interrupt bit
      poke(16'h0478, 16'h4000);
      poke(16'h0479, 16'h08ae);
      poke(16'h0408, 16'h0000);
      poke(16'h0409, 16'h0a00);
      for (i = 0; i < 32; i++) poke(16'h0868 + i, rnd());
      // Index mode transmit twice from pointer A
      repeat (2) begin
         msg(cmd(1'b1, 5'h01, 5'h03), 1'b0, -1);
         for (i = 0; i < 3; i++) chk("tx_word", txq[i], mm[16'h0868 + i]);
         chk("tx_count", 16'(txq.size()), 16'h0003);
         chk("tx_status", 16'(st_n), 16'h0001);
         chk("tx_irq", 16'(irq_n), 16'h0001);
         chk("cur_cb", o_cur_cb_addr, 16'h0484);
         chk("cur_cmd", o_cur_cmd, cmd(1'b1, 5'h01, 5'h03));
      end
      // Ping-pong receive alternates buffers
      for (i = 0; i < 2; i++) begin
         msg(cmd(1'b0, 5'h01, 5'h02), 1'b0, -1);
         j = i ? 16'h0822 : 16'h0800;
         chk("rx_w0", peek(j + 2), rxq[0]);
         chk("rx_w1", peek(j + 3), rxq[1]);
         chk("rx_info", peek(j), 16'h0002);
         chk("select", peek(16'h0404), i ? 16'h4004 : 16'h6004);
      end
      // Loopback subaddress, full count
      msg(cmd(1'b0, 5'h1e, 5'h00), 1'b0, -1);
      q = rxq;
      msg(cmd(1'b1, 5'h1e, 5'h00), 1'b0, -1);
      for (i = 0; i < 32; i++) chk("loop_word", txq[i], q[i]);
      chk("loop_count", 16'(txq.size()), 16'h0020);
      // Interrupt bit clear
      msg(cmd(1'b0, 5'h02, 5'h01), 1'b0, -1);
      chk("quiet_status", 16'(st_n), 16'h0001);
      chk("quiet_irq", 16'(irq_n), 16'h0000);
      // Either enable off blocks the interrupt
      for (i = 1; i < 3; i++) begin
         {i_int_enable, i_int_out_enable} = 2'(i);
         msg(cmd(1'b1, 5'h01, 5'h01), 1'b0, -1);
         chk("gated_irq", 16'(irq_n), 16'h0000);
      end
      {i_int_enable, i_int_out_enable} = 2'h3;
      // Broadcast receive
      msg(cmd(1'b0, 5'h01, 5'h01), 1'b1, -1);
      chk("bc_word", peek(16'h0846), rxq[0]);
      chk("bc_status", 16'(st_n), 16'h0000);
      // Errored word aborts
      msg(cmd(1'b0, 5'h01, 5'h03), 1'b0, 1);
      chk("err_status", 16'(st_n), 16'h0000);
      chk("err_irq", 16'(irq_n), 16'h0000);
      chk("err_select", peek(16'h0404), 16'h4004);
      // Mode-code and broadcast transmit commands are ignored
      for (i = 0; i < 2; i++) begin
         msg(cmd(1'b1, i ? 5'h01 : 5'h1f, 5'h01), i[0], -1);
         chk("refused_words", 16'(txq.size() + st_n), 16'h0000);
         chk("refused_cmd", o_cur_cmd, cmd(1'b0, 5'h01, 5'h01));
      end
      // Reset in mid-run clears the last-message registers
      i_sys_rst = 1'b1;
      repeat (2) @(negedge i_clk);
      i_sys_rst = 1'b0;
      @(negedge i_clk);
      chk("rst_cur_cb", o_cur_cb_addr, 16'h0000);
      chk("rst_cur_cmd", o_cur_cmd, 16'h0000);
      msg(cmd(1'b1, 5'h01, 5'h01), 1'b0, -1);
      chk("after_rst", txq[0], mm[16'h0868]);
      chk("after_rst_cb", o_cur_cb_addr, 16'h0484);
      tally_and_finish();
   end
endmodule : tb_top
